// >>> design/blk_rx_pkg.sv
// Package for the block link receive error handler.
// Assumes a single 200 MHz core clock domain.
package blk_rx_pkg;
    // Control codes on the line
    localparam logic [7:0] CODE_START  = 8'h02;
    localparam logic [7:0] CODE_ESCACK = 8'h10;
    localparam logic [7:0] CODE_END    = 8'h03;
    localparam logic [7:0] CODE_NEG    = 8'h15;

    // Receive store
    localparam int STORE_BYTES = 2000;
    localparam int ADDR_W      = 11;
    localparam int MAX_FRAMES  = 10;
    localparam int FCNT_W      = 4;
    localparam logic [FCNT_W-1:0] FRAMES_ALL = 4'h0;

    // Timing
    localparam longint CLK_HZ       = 200_000_000;
    localparam longint BLOCK_WAIT_S = 4;
    localparam longint BLOCK_WAIT_CYC = BLOCK_WAIT_S * CLK_HZ;
    localparam int TMR_W = 30;

    // Error numbers
    localparam logic [7:0] ERR_NONE     = 8'h00;
    localparam logic [7:0] ERR_CHAR     = 8'h01;
    localparam logic [7:0] ERR_CHECK    = 8'h02;
    localparam logic [7:0] ERR_TIMEOUT  = 8'h03;
    localparam logic [7:0] ERR_BREAK    = 8'h04;
    localparam logic [7:0] ERR_CHARDLY  = 8'h05;
    localparam logic [7:0] ERR_RETRYTMO = 8'h06;
    localparam logic [7:0] ERR_STORE    = 8'h07;

    typedef enum {
        ST_IDLE, ST_DATA, ST_ESC, ST_CHECK, ST_RETRYWAIT
    } rx_state_t;
endpackage

// >>> design/block_link_rx.sv
// Receive side of the acknowledged block protocol with ring frame store.
// Assumes rx bytes and line status come in already decoded on core_clk,
// and send requests come from a local transmitter on the same clock.
`timescale 1ns/100ps
// Function
// - Receive store holds 2000 bytes shared by all frames.
// - Option picks overwrite of unread data or protection against it; with protectEn a full store still overwrites the unread byte at wp_q.
// - Frame limit 1 to 10, or zero meaning whole store usable.
// - Store emptied at startup by option or by host command.
// - Store is a ring; oldest frame goes to host first.
// - Limit 1 without protection: newest frame replaces stored one.
// - After end sequence compare check char; positive ack only if clean.
// - Bad block gets negative ack then block wait of 4 s.
// - Abort when attempts exhausted or retry never starts in time.
// - Start answered by start within ack delay is a conflict.
// - Lower priority drops its send and answers positive ack.
// - Higher priority keeps sending its block normally.
// - Lower priority may send after the other transfer releases.
// - Final failure reports first error number, then idle.
// - Retry up to max attempts; abort when exhausted or new error kind.
// - Break reports error at once and starts no repetition.
// - Break status clears itself when line idles again.
// - Character errors share one number, same for send and receive.
// - Character errors reported only after repetitions fail.
// - Start 02h, ack and escape 10h, end 03h.
// - Check is XOR of user bytes through end code, doubled escape twice.
// - Doubled escape in data stores one byte.
// - Character delay expiry: negative ack, error, no repetition; ignored in ST_CHECK while the check char is awaited.
module block_link_rx #(
    parameter longint BLOCK_WAIT = blk_rx_pkg::BLOCK_WAIT_CYC
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    // Received characters from the line
    input  wire logic                          rxValid,
    input  wire logic [7:0]                    rxByte,
    input  wire logic                          rxCharErr,
    input  wire logic                          lineBreak,
    input  wire logic                          charDelayExp,
    input  wire logic                          ackDelayOpen,
    // Local transmit interplay
    input  wire logic                          sendPending,
    input  wire logic                          prioHigh,
    output logic                               sendWithdraw,
    output logic                               sendAllowed,
    // Reply byte request
    output logic                               txReq,
    output logic [7:0]                         txByte,
    // Configuration
    input  wire logic                          protectEn,
    input  wire logic [blk_rx_pkg::FCNT_W-1:0] frameLimit,
    input  wire logic [3:0]                    maxAttempts,
    input  wire logic                          clearAtStart,
    input  wire logic                          clearCmd,
    // Host register-style port
    input  wire logic [3:0]                    regAddr,
    input  wire logic [15:0]                   regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output logic [15:0]                        regRdata,
    // Error report
    output logic                               errPulse,
    output logic [7:0]                         errCode,
    output logic                               breakStatus
);
    import blk_rx_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic brk1_q, brk2_q, brk1_d, brk2_d;
    always_comb begin
        brk1_d = lineBreak;
        brk2_d = brk1_q;
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            brk1_q <= 1'b0;
            brk2_q <= 1'b0;
        end else begin
            brk1_q <= brk1_d;
            brk2_q <= brk2_d;
        end
    end

    // Host port addresses
    localparam logic [3:0] A_DATA  = 4'h0;
    localparam logic [3:0] A_COUNT = 4'h1;
    localparam logic [3:0] A_ERR   = 4'h2;
    localparam logic [3:0] A_CMD   = 4'h3;
    localparam int CMD_CLR_BIT = 0;

    function automatic logic [ADDR_W-1:0] wrapInc(input logic [ADDR_W-1:0] p);
        wrapInc = (p == ADDR_W'(STORE_BYTES - 1)) ? '0 : ADDR_W'(p + 1'b1);
    endfunction

    // ------------------------------------------------------------
    // Ring store
    // ------------------------------------------------------------
    logic [7:0] mem [STORE_BYTES];
    logic [7:0] lenMem [MAX_FRAMES];
    logic [ADDR_W-1:0] wp_q, wp_d, fs_q, fs_d, rp_q, rp_d;
    logic [ADDR_W:0]   used_q, used_d;
    logic [FCNT_W-1:0] nfr_q, nfr_d, fh_q, fh_d, ft_q, ft_d;
    logic [7:0]        flen_q, flen_d, rlen_q, rlen_d;
    logic              started_q, started_d;

    // ------------------------------------------------------------
    // Receive state machine
    // ------------------------------------------------------------
    rx_state_t st_q, st_d;
    logic [7:0]  chk_q, chk_d;
    logic        bad_q, bad_d;
    logic [3:0]  att_q, att_d;
    logic [7:0]  firstErr_q, firstErr_d, lastErr_q, lastErr_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic        txReq_d, errPulse_d, wd_d, wd_q, allow_d, allow_q;
    logic [7:0]  txByte_d, errCode_d, rd_d;
    logic        brkSeen_q, brkSeen_d;
    logic        memWr;
    logic        popFrame, clearNow;
    logic        frameFull, storeFull;

    always_comb begin
        storeFull = (used_q >= (ADDR_W+1)'(STORE_BYTES));
        frameFull = (frameLimit == FRAMES_ALL) ? (nfr_q == FCNT_W'(MAX_FRAMES))
                                               : (nfr_q >= frameLimit);
    end

    always_comb begin
        st_d       = st_q;
        chk_d      = chk_q;
        bad_d      = bad_q;
        att_d      = att_q;
        firstErr_d = firstErr_q;
        lastErr_d  = lastErr_q;
        tmr_d      = tmr_q;
        txReq_d    = 1'b0;
        txByte_d   = txByte;
        errPulse_d = 1'b0;
        errCode_d  = errCode;
        wd_d       = wd_q;
        allow_d    = allow_q;
        brkSeen_d  = brkSeen_q;
        memWr      = 1'b0;
        if (brk2_q && !brkSeen_q) begin
            brkSeen_d  = 1'b1;
            errPulse_d = 1'b1;
            errCode_d  = ERR_BREAK;
            st_d       = ST_IDLE;
            att_d      = '0;
            firstErr_d = ERR_NONE;
        end else if (!brk2_q) begin
            // Clearing the status must not stall the receiver for a cycle
            brkSeen_d = 1'b0;
            if (rxValid && rxCharErr && st_q != ST_IDLE) begin
                bad_d = 1'b1;
                if (firstErr_q == ERR_NONE) firstErr_d = ERR_CHAR;
            end
            case (st_q)
                ST_IDLE, ST_RETRYWAIT: begin
                    if (st_q == ST_RETRYWAIT) begin
                        tmr_d = tmr_q + 1'b1;
                        if (TMR_W'(BLOCK_WAIT) <= tmr_q) begin
                            errPulse_d = 1'b1;
                            errCode_d  = firstErr_q;
                            st_d       = ST_IDLE;
                            att_d      = '0;
                            firstErr_d = ERR_NONE;
                        end
                    end
                    if (rxValid && rxByte == CODE_START) begin
                        if (sendPending && ackDelayOpen && !prioHigh) begin
                            wd_d = 1'b1;
                        end
                        if (sendPending && ackDelayOpen && prioHigh) begin
                            // Keep sending; partner yields
                        end else if (frameFull && protectEn) begin
                            txReq_d  = 1'b1;
                            txByte_d = CODE_NEG;
                            errPulse_d = 1'b1;
                            errCode_d  = ERR_STORE;
                        end else begin
                            txReq_d  = 1'b1;
                            txByte_d = CODE_ESCACK;
                            st_d     = ST_DATA;
                            chk_d    = '0;
                            bad_d    = 1'b0;
                            tmr_d    = '0;
                        end
                    end
                end
                ST_DATA: begin
                    if (charDelayExp) begin
                        txReq_d    = 1'b1;
                        txByte_d   = CODE_NEG;
                        errPulse_d = 1'b1;
                        errCode_d  = ERR_CHARDLY;
                        st_d       = ST_IDLE;
                        att_d      = '0;
                        firstErr_d = ERR_NONE;
                    end else if (rxValid) begin
                        chk_d = chk_q ^ rxByte;
                        if (rxByte == CODE_ESCACK) st_d = ST_ESC;
                        else memWr = 1'b1;
                    end
                end
                ST_ESC: begin
                    if (charDelayExp) begin
                        txReq_d    = 1'b1;
                        txByte_d   = CODE_NEG;
                        errPulse_d = 1'b1;
                        errCode_d  = ERR_CHARDLY;
                        st_d       = ST_IDLE;
                    end else if (rxValid) begin
                        chk_d = chk_q ^ rxByte;
                        if (rxByte == CODE_ESCACK) begin
                            memWr = 1'b1;
                            st_d  = ST_DATA;
                        end else begin
                            if (rxByte != CODE_END) bad_d = 1'b1;
                            st_d = ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (rxValid) begin
                        txReq_d = 1'b1;
                        if (rxByte == chk_q && !bad_q && !rxCharErr) begin
                            txByte_d   = CODE_ESCACK;
                            st_d       = ST_IDLE;
                            att_d      = '0;
                            firstErr_d = ERR_NONE;
                        end else begin
                            txByte_d = CODE_NEG;
                            if (firstErr_q == ERR_NONE && rxByte != chk_q && !bad_q)
                                firstErr_d = ERR_CHECK;
                            lastErr_d = bad_q ? ERR_CHAR : ERR_CHECK;
                            att_d = att_q + 1'b1;
                            tmr_d = '0;
                            if (att_q + 1'b1 >= maxAttempts ||
                                (lastErr_q != ERR_NONE &&
                                 lastErr_q != (bad_q ? ERR_CHAR : ERR_CHECK))) begin
                                errPulse_d = 1'b1;
                                errCode_d  = (firstErr_q == ERR_NONE) ?
                                             (bad_q ? ERR_CHAR : ERR_CHECK) : firstErr_q;
                                st_d       = ST_IDLE;
                                att_d      = '0;
                                firstErr_d = ERR_NONE;
                                lastErr_d  = ERR_NONE;
                            end else begin
                                st_d = ST_RETRYWAIT;
                            end
                        end
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
        // Withdrawn send released once the link is idle again
        allow_d = wd_q && st_d == ST_IDLE && st_q != ST_IDLE;
        if (allow_d) wd_d = 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q       <= ST_IDLE;
            chk_q      <= '0;
            bad_q      <= 1'b0;
            att_q      <= '0;
            firstErr_q <= ERR_NONE;
            lastErr_q  <= ERR_NONE;
            tmr_q      <= '0;
            txReq      <= 1'b0;
            txByte     <= 8'h00;
            errPulse   <= 1'b0;
            errCode    <= ERR_NONE;
            wd_q       <= 1'b0;
            allow_q    <= 1'b0;
            brkSeen_q  <= 1'b0;
        end else begin
            st_q       <= st_d;
            chk_q      <= chk_d;
            bad_q      <= bad_d;
            att_q      <= att_d;
            firstErr_q <= firstErr_d;
            lastErr_q  <= lastErr_d;
            tmr_q      <= tmr_d;
            txReq      <= txReq_d;
            txByte     <= txByte_d;
            errPulse   <= errPulse_d;
            errCode    <= errCode_d;
            wd_q       <= wd_d;
            allow_q    <= allow_d;
            brkSeen_q  <= brkSeen_d;
        end
    end
    assign sendWithdraw = wd_q;
    assign sendAllowed  = allow_q;
    assign breakStatus  = brkSeen_q;

    // ------------------------------------------------------------
    // Store pointers and host reads
    // ------------------------------------------------------------
    logic frameDone, needDrop;
    always_comb begin
        frameDone = (st_q == ST_CHECK) && (st_d == ST_IDLE) && txByte_d == CODE_ESCACK
                    && txReq_d;
        needDrop  = frameDone && frameFull && !protectEn;
        clearNow  = (clearAtStart && !started_q) ||
                    (regWr && regAddr == A_CMD && regWdata[CMD_CLR_BIT]) || clearCmd;
        popFrame  = regRd && regAddr == A_DATA && nfr_q != '0 && rlen_q == 8'd1;
    end

    always_comb begin
        wp_d = wp_q; fs_d = fs_q; rp_d = rp_q; used_d = used_q;
        nfr_d = nfr_q; fh_d = fh_q; ft_d = ft_q; flen_d = flen_q; rlen_d = rlen_q;
        started_d = 1'b1;
        rd_d = 8'h00;
        if (clearNow) begin
            wp_d = '0; fs_d = '0; rp_d = '0; used_d = '0;
            nfr_d = '0; fh_d = '0; ft_d = '0; flen_d = '0; rlen_d = '0;
        end else begin
            if (memWr && !(storeFull && protectEn)) begin
                wp_d = wrapInc(wp_q);
                flen_d = flen_q + 1'b1;
                used_d = used_q + 1'b1;
            end
            if (st_q == ST_IDLE || st_q == ST_RETRYWAIT) begin
                wp_d = fs_q;                                     // discard partial frame
                used_d = used_q - (ADDR_W+1)'(flen_q);
                flen_d = '0;
            end
            if (frameDone) begin
                fs_d = wp_q;
                flen_d = '0;
                ft_d = (ft_q == FCNT_W'(MAX_FRAMES-1)) ? '0 : FCNT_W'(ft_q + 1'b1);
                nfr_d = needDrop ? nfr_q : FCNT_W'(nfr_q + 1'b1);
                if (needDrop) begin
                    rp_d = fs_q;
                    fh_d = ft_q;
                    used_d = (ADDR_W+1)'(flen_q);
                end
            end
            if (regRd && regAddr == A_DATA && nfr_q != '0 && !needDrop) begin
                rd_d = mem[rp_q];
                rp_d = wrapInc(rp_q);
                used_d = used_d - 1'b1;
                rlen_d = (rlen_q == '0) ? lenMem[fh_q] - 1'b1 : rlen_q - 1'b1;
                if (popFrame || lenMem[fh_q] == 8'd1 && rlen_q == '0) begin
                    fh_d = (fh_q == FCNT_W'(MAX_FRAMES-1)) ? '0 : FCNT_W'(fh_q + 1'b1);
                    nfr_d = nfr_d - 1'b1;
                    rlen_d = '0;
                end
            end else if (regRd && regAddr == A_COUNT) begin
                rd_d = {4'h0, nfr_q};
            end else if (regRd && regAddr == A_ERR) begin
                rd_d = errCode;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (memWr) mem[wp_q] <= rxByte;
        if (frameDone) lenMem[ft_q] <= flen_q;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wp_q <= '0; fs_q <= '0; rp_q <= '0; used_q <= '0;
            nfr_q <= '0; fh_q <= '0; ft_q <= '0; flen_q <= '0; rlen_q <= '0;
            started_q <= 1'b0;
            regRdata <= 16'h0000;
        end else begin
            wp_q <= wp_d; fs_q <= fs_d; rp_q <= rp_d; used_q <= used_d;
            nfr_q <= nfr_d; fh_q <= fh_d; ft_q <= ft_d; flen_q <= flen_d;
            rlen_q <= rlen_d;
            started_q <= started_d;
            regRdata <= {8'h00, rd_d};
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    ack_on_good_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == ST_CHECK && rxValid && rxByte == chk_q && !bad_q && !rxCharErr && !brk2_q)
        |=> txReq && txByte == CODE_ESCACK) else $error("good block not acked");
    nak_on_bad_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == ST_CHECK && rxValid && rxByte != chk_q && !brk2_q)
        |=> txReq && txByte == CODE_NEG) else $error("bad block not refused");
    break_report_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(brk2_q) |=> errPulse && errCode == ERR_BREAK) else $error("break missed");
    break_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (breakStatus && !brk2_q) |=> !breakStatus) else $error("break stuck");
    char_delay_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == ST_DATA && charDelayExp && !brk2_q) |=> st_q == ST_IDLE && txByte == CODE_NEG)
        else $error("char delay not handled");
    store_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
        used_q <= (ADDR_W+1)'(STORE_BYTES)) else $error("store overrun");
    frame_limit_a: assert property (@(posedge core_clk) disable iff (!resetn)
        nfr_q <= FCNT_W'(MAX_FRAMES)) else $error("frame count over");
    withdraw_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == ST_IDLE && rxValid && rxByte == CODE_START && sendPending && ackDelayOpen
         && !prioHigh && !brk2_q && !frameFull) |=> sendWithdraw && txByte == CODE_ESCACK)
        else $error("low prio not yielding");
    good_frame_c: cover property (@(posedge core_clk) frameDone);
    retry_c: cover property (@(posedge core_clk) st_q == ST_RETRYWAIT);
    conflict_c: cover property (@(posedge core_clk) sendAllowed);
endmodule

// >>> testbench/peer_station.sv
// Peer station model: sends framed blocks and keeps the last reply byte.
// Assumes replies come as txReq/txByte pulses on core_clk.
`timescale 1ns/100ps
module peer_station (
    // Clock
    input  wire logic       core_clk,
    // Line toward the receiver
    output logic            rxValid,
    output logic [7:0]      rxByte,
    // Replies from the receiver
    input  wire logic       txReq,
    input  wire logic [7:0] txByte
);
    import blk_rx_pkg::*;
    logic [7:0] lastReply = 8'h00;
    initial rxValid = 1'b0;
    initial rxByte = 8'h00;
    always @(posedge core_clk) if (txReq === 1'b1) lastReply <= txByte;
    task automatic put(input logic [7:0] b);
        @(posedge core_clk);
        rxValid <= 1'b1;
        rxByte  <= b;
        @(posedge core_clk);
        rxValid <= 1'b0;
        rxByte  <= ~b; // Released line must not keep the last byte
    endtask
    // Bad selects a wrong check byte; escapes in data go out doubled
    task automatic frame(input logic [23:0] d, input logic bad);
        logic [7:0] x;
        x = 8'h00;
        put(CODE_START);
        for (int i = 2; i >= 0; i--) begin
            put(d[i*8+:8]);
            x = x ^ d[i*8+:8];
            if (d[i*8+:8] == CODE_ESCACK) begin
                put(CODE_ESCACK);
                x = x ^ CODE_ESCACK;
            end
        end
        put(CODE_ESCACK);
        put(CODE_END);
        x = x ^ CODE_ESCACK ^ CODE_END;
        put(bad ? ~x : x);
    endtask
endmodule

// >>> testbench/block_link_receive_error_handler_test.sv
// Self-checking bench for the block receiver against a peer model.
// Assumes one 200 MHz clock; block wait shortened to 50 cycles.
`timescale 1ns/100ps
module block_link_receive_error_handler_test;
    import blk_rx_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, rxValid, txReq, errPulse, breakStatus;
    logic rxCharErr = 1'b0, lineBreak = 1'b0, ackDelayOpen = 1'b0, sendPending = 1'b0;
    logic prioHigh = 1'b1, regWr = 1'b0, regRd = 1'b0, sendWithdraw, sendAllowed;
    logic [7:0] rxByte, txByte, errCode;
    logic [3:0] regAddr = 4'h0, maxAttempts = 4'h2, frameLimit = 4'h0;
    logic [15:0] regWdata = 16'h0000, regRdata;
    logic charDelayExp = 1'b0;
    int err_total = 0, compares = 0, errSeen = 0, allowSeen = 0;
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (errPulse === 1'b1) errSeen++;
    always @(posedge core_clk) if (sendAllowed === 1'b1) allowSeen++;
    peer_station peer (.core_clk(core_clk), .rxValid(rxValid), .rxByte(rxByte),
        .txReq(txReq), .txByte(txByte));
    block_link_rx #(.BLOCK_WAIT(50)) dut (.core_clk(core_clk), .resetn(resetn),
        .rxValid(rxValid), .rxByte(rxByte), .rxCharErr(rxCharErr), .lineBreak(lineBreak),
        .charDelayExp(charDelayExp), .ackDelayOpen(ackDelayOpen), .sendPending(sendPending),
        .prioHigh(prioHigh), .sendWithdraw(sendWithdraw), .sendAllowed(sendAllowed),
        .txReq(txReq), .txByte(txByte), .protectEn(1'b0), .frameLimit(frameLimit),
        .maxAttempts(maxAttempts), .clearAtStart(1'b1), .clearCmd(1'b0),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .errPulse(errPulse), .errCode(errCode),
        .breakStatus(breakStatus));
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWr <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
        @(posedge core_clk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 check(nm, exp, regRdata);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_ring;
        wr(4'h3, 16'h0001);
        peer.frame(24'h41_1042, 1'b0);
        idle(3);
        check("ack", {8'h00, CODE_ESCACK}, {8'h00, peer.lastReply});
        peer.frame(24'h51_5253, 1'b0);
        idle(3);
        rd(4'h1, 16'h0002, "frames");
        rd(4'h0, 16'h0041, "byte0");
        rd(4'h0, 16'h0010, "byte1");
        rd(4'h0, 16'h0042, "byte2");
        rd(4'h0, 16'h0051, "byte3");
        rd(4'hF, 16'h0000, "unmapped");
    endtask
    task automatic t_retry;
        int e0;
        e0 = errSeen;
        peer.frame(24'h61_6263, 1'b1);
        idle(3);
        check("nak", {8'h00, CODE_NEG}, {8'h00, peer.lastReply});
        check("early", e0, errSeen);
        peer.frame(24'h61_6263, 1'b1);
        idle(60);
        check("abort", e0 + 1, errSeen);
        check("first", {8'h00, ERR_CHECK}, {8'h00, errCode});
    endtask
    task automatic t_conflict;
        sendPending <= 1'b1; ackDelayOpen <= 1'b1; prioHigh <= 1'b0;
        peer.put(CODE_START);
        idle(3);
        check("yield", {8'h00, CODE_ESCACK}, {8'h00, peer.lastReply});
        check("withdraw", 16'h0001, {15'h0, sendWithdraw});
        ackDelayOpen <= 1'b0;
    endtask
    task automatic t_break;
        lineBreak <= 1'b1;
        idle(6);
        check("brk", 16'h0001, {15'h0, breakStatus});
        check("brkcode", {8'h00, ERR_BREAK}, {8'h00, errCode});
        lineBreak <= 1'b0;
        idle(6);
        check("brkclr", 16'h0000, {15'h0, breakStatus});
        check("allowed", 16'h0001, allowSeen[15:0]);
        check("wdclr", 16'h0000, {15'h0, sendWithdraw});
    endtask
    task automatic t_chardly;
        int e0;
        e0 = errSeen;
        peer.put(CODE_START);
        peer.put(8'h55);
        charDelayExp <= 1'b1;
        idle(1);
        charDelayExp <= 1'b0;
        idle(3);
        check("cdnak", {8'h00, CODE_NEG}, {8'h00, peer.lastReply});
        check("cdcode", {8'h00, ERR_CHARDLY}, {8'h00, errCode});
        check("cdcount", e0 + 1, errSeen);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #20_000;
        err_total++;
        finish_test();
    end
    initial begin
        idle(16);
        resetn <= 1'b1;
        idle(2);
        t_ring();
        t_retry();
        t_conflict();
        t_break();
        t_chardly();
        finish_test();
    end
endmodule
